// file: logic/pew_pkg.sv
package pew_pkg;
  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int PAGE_BYTES = 128;
  localparam int PAGE_LSB = 7;
  localparam int DQ_POLL_BIT = 7;
  localparam int DQ_TOGGLE_BIT = 6;
  localparam int SEQ_MAX = 6;
  localparam int UNLOCK_LEN = 3;
  localparam int RESET_LEN = 6;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int LOAD_WINDOW_NS = 100000;
  // Longest wait rounds down so the host never overruns the window
  localparam int LOAD_WINDOW_CYC = LOAD_WINDOW_NS / CLK_PERIOD_NS;
  localparam int WE_PULSE_MIN_NS = 10;
  // Least time rounds up; one extra cycle keeps well clear of the filter
  localparam int WE_PULSE_CYC = (WE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int SETUP_CYC = 2;
  localparam int READ_CYC = 16;
  localparam int POLL_LIMIT_NS = 10000000;
  localparam int POLL_LIMIT_CYC = POLL_LIMIT_NS / CLK_PERIOD_NS;
  // ---------------------------------------------------------------
  // Commands and carriers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PEW_CMD_READ,
    PEW_CMD_WRITE,
    PEW_CMD_PROT_WRITE,
    PEW_CMD_PROT_RESET
  } pew_cmd_t;

  typedef struct packed {
    pew_cmd_t cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic last;
  } pew_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pew_pair_t;

  typedef struct packed {
    logic device_select_n;
    logic output_drive_n;
    logic write_strobe_n;
    logic [ADDR_W-1:0] byte_address;
    logic [DATA_W-1:0] data_out;
    logic data_oe;
  } pew_pins_t;
endpackage

// file: logic/pew_bus_cycle.sv
// Drives one strobe cycle on the pins: setup, active, release.
module pew_bus_cycle
  import pew_pkg::*;
#(
  parameter int ACTIVE_CYC = WE_PULSE_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic is_write,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W-1:0] data_in,
  output pew_pins_t pins,
  output logic [DATA_W-1:0] rdata,
  output logic done
);
  typedef enum logic [1:0] {PBC_IDLE, PBC_SETUP, PBC_ACT, PBC_HOLD} pbc_state_t;
  typedef struct packed {
    pbc_state_t st;
    logic [7:0] cnt;
    logic wr;
    pew_pins_t pins;
    logic [DATA_W-1:0] rdata;
    logic done;
  } pbc_s_t;
  pbc_s_t s_ff;
  pbc_s_t nxt_s;
  localparam logic [7:0] RD_LEN = 8'(READ_CYC);
  localparam logic [7:0] WR_LEN = 8'(ACTIVE_CYC);

  always_comb begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    unique case (s_ff.st)
      PBC_IDLE: begin
        if (start) begin
          nxt_s.st = PBC_SETUP;
          nxt_s.wr = is_write;
          nxt_s.cnt = 8'(SETUP_CYC);
          nxt_s.pins.byte_address = addr;
          nxt_s.pins.data_out = wdata;
          // Own drive only on writes; device drives data_io on reads
          nxt_s.pins.data_oe = is_write;
          nxt_s.pins.output_drive_n = is_write ? 1'b1 : 1'b0;
        end
      end
      PBC_SETUP: begin
        if (s_ff.cnt == 8'h00) begin
          nxt_s.st = PBC_ACT;
          // Address settles before select falls, together with the write strobe on writes
          nxt_s.pins.device_select_n = 1'b0;
          nxt_s.pins.write_strobe_n = !s_ff.wr;
          nxt_s.cnt = s_ff.wr ? WR_LEN : RD_LEN;
        end else begin
          nxt_s.cnt = s_ff.cnt - 8'h01;
        end
      end
      PBC_ACT: begin
        if (s_ff.cnt == 8'h00) begin
          nxt_s.st = PBC_HOLD;
          nxt_s.rdata = data_in;
          // Strobe pulse of several cycles clears the noise filter
          nxt_s.pins.write_strobe_n = 1'b1;
          nxt_s.pins.device_select_n = 1'b1;
          nxt_s.pins.output_drive_n = 1'b1;
        end else begin
          nxt_s.cnt = s_ff.cnt - 8'h01;
        end
      end
      PBC_HOLD: begin
        // Data held one more cycle past the strobe rise
        nxt_s.pins.data_oe = 1'b0;
        nxt_s.st = PBC_IDLE;
        nxt_s.done = 1'b1;
      end
      default: nxt_s.st = PBC_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_ff <= '0;
      s_ff.pins.device_select_n <= 1'b1;
      s_ff.pins.output_drive_n <= 1'b1;
      s_ff.pins.write_strobe_n <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign pins = s_ff.pins;
  assign rdata = s_ff.rdata;
  assign done = s_ff.done;

  AST_NO_CONTENTION: assert property (@(posedge clk) disable iff (sys_rst)
    !s_ff.pins.output_drive_n |-> !s_ff.pins.data_oe)
    else $error("host drives data during read");
  AST_WRITE_NEEDS_OE_HIGH: assert property (@(posedge clk) disable iff (sys_rst)
    !s_ff.pins.write_strobe_n |-> s_ff.pins.output_drive_n && !s_ff.pins.device_select_n)
    else $error("write strobe without proper enables");
  AST_DATA_HELD_AT_RISE: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(s_ff.pins.write_strobe_n) |-> s_ff.pins.data_oe)
    else $error("data released before strobe rise");
  AST_PULSE_WIDTH: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(s_ff.pins.write_strobe_n) |-> !s_ff.pins.write_strobe_n [*2])
    else $error("write pulse too short");
endmodule // pew_bus_cycle

// file: logic/pew_host.sv
// Behaviour
// - Read while select and output drive low
// - Write needs select, strobe low, drive high
// - Page write loads one to 128 bytes
// - Keep address bits 15..7 within page
// - Next load within 100 us of last
// - Protected: unlock before every write
// - Six-write sequence clears protection
module pew_host
  import pew_pkg::*;
#(
  parameter int LOAD_WINDOW = LOAD_WINDOW_CYC,
  parameter int POLL_LIMIT = POLL_LIMIT_CYC,
  parameter int PAGE_MAX = PAGE_BYTES,
  parameter pew_pair_t UNLOCK_SEQ [UNLOCK_LEN] = '{'{16'h5555, 8'haa},
    '{16'h2aaa, 8'h55}, '{16'h5555, 8'ha0}},
  parameter pew_pair_t RESET_SEQ [RESET_LEN] = '{'{16'h5555, 8'haa},
    '{16'h2aaa, 8'h55}, '{16'h5555, 8'h80}, '{16'h5555, 8'haa},
    '{16'h2aaa, 8'h55}, '{16'h5555, 8'h20}}
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input pew_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  output logic rsp_timeout,
  output logic device_select_n,
  output logic output_drive_n,
  output logic write_strobe_n,
  output logic [ADDR_W-1:0] byte_address,
  output logic [DATA_W-1:0] data_io_out,
  output logic data_io_oe,
  input wire logic [DATA_W-1:0] data_io_in
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_IDLE, PH_SEQ, PH_LOAD, PH_WAIT_REQ, PH_POLL_A, PH_POLL_B, PH_READ
  } ph_state_t;

  typedef struct packed {
    ph_state_t st;
    logic [$clog2(SEQ_MAX+1)-1:0] seq_idx;
    logic [$clog2(SEQ_MAX+1)-1:0] seq_len;
    logic is_reset;
    logic [31:0] gap;
    logic [31:0] poll_cnt;
    logic [ADDR_W-1:0] page_addr;
    logic [7:0] loaded;
    logic [DATA_W-1:0] last_data;
    logic [DATA_W-1:0] tog_prev;
    logic cyc_busy;
    pew_req_t cur;
    logic req_ready;
    logic rsp_valid;
    logic [DATA_W-1:0] rsp_data;
    logic rsp_timeout;
  } ph_s_t;

  ph_s_t s_ff;
  ph_s_t nxt_s;
  logic cyc_start;
  logic cyc_write;
  logic [ADDR_W-1:0] cyc_addr;
  logic [DATA_W-1:0] cyc_wdata;
  pew_pins_t cyc_pins;
  logic [DATA_W-1:0] cyc_rdata;
  logic cyc_done;

  // Sequence step lookup, used for both unlock and reset
  function automatic pew_pair_t seq_pair(input logic rst_seq, input int idx);
    pew_pair_t p;
    p = '0;
    if (rst_seq) begin
      p = RESET_SEQ[idx];
    end else if (idx < UNLOCK_LEN) begin
      // Index left over from a reset sequence must not run off the table
      p = UNLOCK_SEQ[idx];
    end
    return p;
  endfunction

  // Page pinning: upper address bits follow the first byte
  function automatic logic [ADDR_W-1:0] pin_page(input logic [ADDR_W-1:0] first,
    input logic [ADDR_W-1:0] a);
    return {first[ADDR_W-1:PAGE_LSB], a[PAGE_LSB-1:0]};
  endfunction

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    pew_pair_t p;
    p = seq_pair(s_ff.is_reset, int'(s_ff.seq_idx));
    nxt_s = s_ff;
    nxt_s.rsp_valid = 1'b0;
    cyc_start = 1'b0;
    cyc_write = 1'b0;
    cyc_addr = s_ff.cur.addr;
    cyc_wdata = s_ff.cur.data;
    if (cyc_done) nxt_s.cyc_busy = 1'b0;
    unique case (s_ff.st)
      PH_IDLE: begin
        nxt_s.req_ready = 1'b1;
        if (req_valid && s_ff.req_ready) begin
          nxt_s.req_ready = 1'b0;
          nxt_s.cur = req;
          nxt_s.seq_idx = '0;
          nxt_s.loaded = 8'h00;
          nxt_s.page_addr = req.addr;
          nxt_s.rsp_timeout = 1'b0;
          unique case (req.cmd)
            PEW_CMD_READ: nxt_s.st = PH_READ;
            PEW_CMD_WRITE: nxt_s.st = PH_LOAD;
            PEW_CMD_PROT_WRITE: begin
              nxt_s.st = PH_SEQ;
              nxt_s.is_reset = 1'b0;
              nxt_s.seq_len = 3'(UNLOCK_LEN);
            end
            PEW_CMD_PROT_RESET: begin
              nxt_s.st = PH_SEQ;
              nxt_s.is_reset = 1'b1;
              nxt_s.seq_len = 3'(RESET_LEN);
            end
          endcase
        end
      end
      PH_SEQ: begin
        // Sequence is not broken by other traffic, per device note
        if (!s_ff.cyc_busy && !cyc_done) begin
          cyc_start = 1'b1;
          cyc_write = 1'b1;
          cyc_addr = p.addr;
          cyc_wdata = p.data;
          nxt_s.cyc_busy = 1'b1;
        end else if (cyc_done) begin
          nxt_s.gap = '0;
          if (s_ff.seq_idx == s_ff.seq_len - 3'd1) begin
            nxt_s.st = s_ff.is_reset ? PH_POLL_A : PH_LOAD;
            nxt_s.last_data = p.data;
            nxt_s.page_addr = p.addr;
          end else begin
            nxt_s.seq_idx = s_ff.seq_idx + 3'd1;
          end
        end
      end
      PH_LOAD: begin
        nxt_s.gap = s_ff.gap + 32'd1;
        if (!s_ff.cyc_busy && !cyc_done) begin
          cyc_start = 1'b1;
          cyc_write = 1'b1;
          cyc_addr = (s_ff.loaded == 8'h00) ? s_ff.cur.addr
            : pin_page(s_ff.page_addr, s_ff.cur.addr);
          nxt_s.cyc_busy = 1'b1;
          nxt_s.gap = '0;
          if (s_ff.loaded == 8'h00) nxt_s.page_addr = s_ff.cur.addr;
        end else if (cyc_done) begin
          nxt_s.loaded = s_ff.loaded + 8'h01;
          nxt_s.last_data = s_ff.cur.data;
          // Poll address must be the pinned one the device really stored
          nxt_s.page_addr = pin_page(s_ff.page_addr, s_ff.cur.addr);
          if (s_ff.cur.last || (s_ff.loaded + 8'h01 == 8'(PAGE_MAX))) begin
            // Last byte loaded; start polling right away instead of waiting out the window
            nxt_s.st = PH_POLL_A;
          end else begin
            nxt_s.st = PH_WAIT_REQ;
            nxt_s.req_ready = 1'b1;
          end
        end
      end
      PH_WAIT_REQ: begin
        nxt_s.gap = s_ff.gap + 32'd1;
        if (req_valid && s_ff.req_ready) begin
          nxt_s.req_ready = 1'b0;
          nxt_s.cur = req;
          nxt_s.st = PH_LOAD;
        end else if (s_ff.gap + 32'(2*SETUP_CYC + 2) >= 32'(LOAD_WINDOW)) begin
          // Too late to fit another load; page is closed by the device
          nxt_s.req_ready = 1'b0;
          nxt_s.st = PH_POLL_A;
        end
      end
      PH_POLL_A, PH_POLL_B: begin
        // Poll the last written address until bit 6 stops toggling and, except after a reset, bit 7 matches last_data
        nxt_s.poll_cnt = s_ff.poll_cnt + 32'd1;
        if (!s_ff.cyc_busy && !cyc_done) begin
          cyc_start = 1'b1;
          cyc_addr = s_ff.page_addr;
          nxt_s.cyc_busy = 1'b1;
        end else if (cyc_done) begin
          nxt_s.tog_prev = cyc_rdata;
          if (s_ff.st == PH_POLL_B
              && cyc_rdata[DQ_TOGGLE_BIT] == s_ff.tog_prev[DQ_TOGGLE_BIT]
              && (s_ff.is_reset
                  || cyc_rdata[DQ_POLL_BIT] == s_ff.last_data[DQ_POLL_BIT])) begin
            nxt_s.st = PH_IDLE;
            nxt_s.rsp_valid = 1'b1;
            nxt_s.rsp_data = cyc_rdata;
            nxt_s.poll_cnt = '0;
            nxt_s.is_reset = 1'b0;
          end else if (s_ff.poll_cnt >= 32'(POLL_LIMIT)) begin
            // Device never finished; report and give up
            nxt_s.st = PH_IDLE;
            nxt_s.rsp_valid = 1'b1;
            nxt_s.rsp_timeout = 1'b1;
            nxt_s.rsp_data = cyc_rdata;
            nxt_s.poll_cnt = '0;
          end else begin
            nxt_s.st = PH_POLL_B;
          end
        end
      end
      PH_READ: begin
        if (!s_ff.cyc_busy && !cyc_done) begin
          cyc_start = 1'b1;
          nxt_s.cyc_busy = 1'b1;
        end else if (cyc_done) begin
          nxt_s.st = PH_IDLE;
          nxt_s.rsp_valid = 1'b1;
          nxt_s.rsp_data = cyc_rdata;
        end
      end
      default: nxt_s.st = PH_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ---------------------------------------------------------------
  // Pin driver
  // ---------------------------------------------------------------
  pew_bus_cycle #(.ACTIVE_CYC(WE_PULSE_CYC)) u_cycle (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(cyc_start),
    .is_write(cyc_write),
    .addr(cyc_addr),
    .wdata(cyc_wdata),
    .data_in(data_io_in),
    .pins(cyc_pins),
    .rdata(cyc_rdata),
    .done(cyc_done)
  );

  assign device_select_n = cyc_pins.device_select_n;
  assign output_drive_n = cyc_pins.output_drive_n;
  assign write_strobe_n = cyc_pins.write_strobe_n;
  assign byte_address = cyc_pins.byte_address;
  assign data_io_out = cyc_pins.data_out;
  assign data_io_oe = cyc_pins.data_oe;
  assign req_ready = s_ff.req_ready;
  assign rsp_valid = s_ff.rsp_valid;
  assign rsp_data = s_ff.rsp_data;
  assign rsp_timeout = s_ff.rsp_timeout;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_LOAD_IN_WINDOW: assert property (@(posedge clk) disable iff (sys_rst)
    s_ff.st == PH_WAIT_REQ |-> s_ff.gap < 32'(LOAD_WINDOW))
    else $error("byte load window exceeded");
  AST_PAGE_PINNED: assert property (@(posedge clk) disable iff (sys_rst)
    cyc_start && s_ff.st == PH_LOAD && s_ff.loaded != 8'h00
    |-> cyc_addr[ADDR_W-1:PAGE_LSB] == s_ff.page_addr[ADDR_W-1:PAGE_LSB])
    else $error("page address changed within a page");
  AST_PAGE_LIMIT: assert property (@(posedge clk) disable iff (sys_rst)
    s_ff.loaded <= 8'(PAGE_MAX))
    else $error("page over 128 bytes");
  AST_NO_WRITE_WHILE_POLL: assert property (@(posedge clk) disable iff (sys_rst)
    (s_ff.st == PH_POLL_A || s_ff.st == PH_POLL_B) |-> !cyc_write)
    else $error("write issued during programming");
  AST_POLL_BOUNDED: assert property (@(posedge clk) disable iff (sys_rst)
    s_ff.poll_cnt <= 32'(POLL_LIMIT) + 32'd64)
    else $error("poll ran past limit");
  AST_RSP_ENDS_POLL: assert property (@(posedge clk) disable iff (sys_rst)
    s_ff.st == PH_POLL_B && nxt_s.st == PH_IDLE |=> rsp_valid && req_ready == 1'b0)
    else $error("poll end without response");
  AST_SEQ_LEN: assert property (@(posedge clk) disable iff (sys_rst)
    s_ff.st == PH_SEQ |-> s_ff.seq_idx < s_ff.seq_len)
    else $error("sequence index overrun");
  AST_READ_DRIVE: assert property (@(posedge clk) disable iff (sys_rst)
    !output_drive_n |-> !data_io_oe && write_strobe_n)
    else $error("write inhibit violated");

  COV_READ: cover property (@(posedge clk) s_ff.st == PH_READ && cyc_done);
  COV_PAGE: cover property (@(posedge clk) s_ff.loaded == 8'h02);
  COV_UNLOCK: cover property (@(posedge clk) s_ff.st == PH_SEQ && !s_ff.is_reset && cyc_done);
  COV_RESET: cover property (@(posedge clk) s_ff.is_reset && s_ff.st == PH_POLL_B);
endmodule // pew_host

// file: dv/pew_dev_model.sv
// ---------------------------------------------------------------
// Behavioural byte-wide memory at the far side of the host
// ---------------------------------------------------------------
module pew_dev_model
  import pew_pkg::*;
#(
  parameter int WIN_NS = 2000,
  parameter int PROG_NS = 3000,
  parameter int GLITCH_NS = 10,
  parameter pew_pair_t UNL = '{16'h5555, 8'ha0},
  parameter pew_pair_t RST [RESET_LEN] = '{'{16'h5555, 8'haa}, '{16'h2aaa, 8'h55},
    '{16'h5555, 8'h80}, '{16'h5555, 8'haa}, '{16'h2aaa, 8'h55}, '{16'h5555, 8'h20}}
) (
  input wire logic device_select_n,
  input wire logic output_drive_n,
  input wire logic write_strobe_n,
  input wire logic [ADDR_W-1:0] byte_address,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [bit [ADDR_W-1:0]];
  pew_pair_t page_q [$];
  logic prog = 1'b0;
  logic prot = 1'b0;
  logic unl = 1'b0;
  logic tog = 1'b0;
  int seq_n = 0;
  realtime wr_t = 0;
  realtime prog_t = 0;
  logic [ADDR_W-1:0] wa;
  logic [DATA_W-1:0] wd;
  logic [DATA_W-1:0] last_d = 8'hff;
  wire rd_act = !device_select_n && !output_drive_n;
  wire wr_act = !device_select_n && !write_strobe_n && output_drive_n;
  assign dq_oe = rd_act;
  initial dq_out = 8'hff;

  function automatic logic hit(pew_pair_t p, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    return a[14:0] == p.addr[14:0] && d == p.data;
  endfunction

  task automatic commit();
    foreach (page_q[i]) mem[page_q[i].addr] = page_q[i].data;
    last_d = page_q[$].data;
    page_q.delete();
    unl = 1'b0;
    prog = 1'b1;
    prog_t = $realtime;
  endtask

  // Later falling strobe is the moment the access becomes a write
  always @(posedge wr_act) begin
    wr_t = $realtime;
    wa = byte_address;
  end

  always @(negedge wr_act) begin
    wd = dq_in;
    if ($realtime - wr_t < GLITCH_NS || prog || $isunknown(wa)) begin
      wd = dq_in;
    end else if (seq_n < RESET_LEN && hit(RST[seq_n], wa, wd)) begin
      seq_n++;
      if (seq_n == RESET_LEN) begin
        seq_n = 0;
        prot = 1'b0;
        prog = 1'b1;
        prog_t = $realtime;
      end
    end else if (seq_n == 2 && hit(UNL, wa, wd)) begin
      seq_n = 0;
      prot = 1'b1;
      unl = 1'b1;
    end else begin
      seq_n = 0;
      if ((!prot || unl) && page_q.size() < PAGE_BYTES) page_q.push_back('{wa, wd});
    end
  end

  always #10 begin
    if (page_q.size() > 0 && !prog && $realtime - wr_t > WIN_NS) commit();
    if (prog && $realtime - prog_t >= PROG_NS) prog = 1'b0;
  end

  // Limitation: a read of this device also ends a pending page load
  always @(posedge rd_act) begin
    if (page_q.size() > 0) commit();
    if (prog) tog = ~tog;
    if (prog) dq_out = {~last_d[7], tog, last_d[5:0]};
    else dq_out = mem.exists(byte_address) ? mem[byte_address] : 8'hff;
  end
endmodule // pew_dev_model

// file: dv/tb_pew_host.sv
module tb_pew_host;
  import pew_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WIN = 200;
  localparam int POLL = 5000;
  typedef struct packed {
    pew_cmd_t cmd;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] x;
    logic t;
  } pew_row_t;
  localparam pew_row_t ROWS [11] = '{
    '{PEW_CMD_WRITE, 16'h0010, 8'h3c, 8'h3c, 1'b0},
    '{PEW_CMD_READ, 16'h0010, 8'h00, 8'h3c, 1'b0},
    '{PEW_CMD_READ, 16'h0011, 8'h00, 8'hff, 1'b0},
    '{PEW_CMD_WRITE, 16'h1234, 8'hc5, 8'hc5, 1'b0},
    '{PEW_CMD_PROT_WRITE, 16'h0300, 8'h77, 8'h77, 1'b0},
    '{PEW_CMD_READ, 16'h0300, 8'h00, 8'h77, 1'b0},
    '{PEW_CMD_WRITE, 16'h0301, 8'h11, 8'hff, 1'b1},
    '{PEW_CMD_READ, 16'h5555, 8'h00, 8'hff, 1'b0},
    '{PEW_CMD_PROT_RESET, 16'h0000, 8'h00, 8'hff, 1'b0},
    '{PEW_CMD_WRITE, 16'h0302, 8'h42, 8'h42, 1'b0},
    '{PEW_CMD_READ, 16'h0302, 8'h00, 8'h42, 1'b0}};
  logic clk;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  pew_req_t req = '0;
  logic req_ready, rsp_valid, rsp_timeout, data_io_oe, dev_oe;
  logic device_select_n, output_drive_n, write_strobe_n;
  logic [ADDR_W-1:0] byte_address;
  logic [DATA_W-1:0] rsp_data, data_io_out, dev_dq;
  int fails = 0;
  int total_checks = 0;
  // Undriven line shows the inverse of the device's last output, never a lucky match
  wire logic [DATA_W-1:0] data_io_in = dev_oe ? dev_dq : (data_io_oe ? data_io_out : ~dev_dq);

  pew_host #(.LOAD_WINDOW(WIN), .POLL_LIMIT(POLL)) dut_u (.clk(clk), .sys_rst(sys_rst),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_timeout(rsp_timeout), .device_select_n(device_select_n),
    .output_drive_n(output_drive_n), .write_strobe_n(write_strobe_n),
    .byte_address(byte_address), .data_io_out(data_io_out), .data_io_oe(data_io_oe),
    .data_io_in(data_io_in));
  pew_dev_model #(.WIN_NS(WIN * CLK_PERIOD_NS)) dev_u (.device_select_n(device_select_n),
    .output_drive_n(output_drive_n), .write_strobe_n(write_strobe_n),
    .byte_address(byte_address), .dq_in(data_io_in), .dq_out(dev_dq), .dq_oe(dev_oe));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(string name, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic send(pew_cmd_t c, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d, logic l);
    int n;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{c, a, d, l};
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 20000);
    if (req_ready !== 1'b1) begin
      fails++;
      $display("[FAIL] req_ready expected 1 seen %b", req_ready);
    end
    @(posedge clk);
    req_valid <= 1'b0;
  endtask

  task automatic expect_rsp(logic [DATA_W-1:0] x, logic t);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 20000);
    check("rsp_valid", 8'h01, 8'(rsp_valid));
    check("rsp_data", x, rsp_data);
    check("rsp_timeout", 8'(t), 8'(rsp_timeout));
  endtask

  // ---------------------------------------------------------------
  // Clock, watchdog and bus monitor
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #900000;
    fails++;
    final_report();
  end

  always @(negedge clk) begin
    if (data_io_oe === 1'b1 && dev_oe === 1'b1) begin
      fails++;
      $display("[FAIL] data_io contention expected 0 seen 1");
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    check("pins_in_reset", 8'h1c, {3'b0, device_select_n, output_drive_n, write_strobe_n,
      data_io_oe, req_ready});
    sys_rst <= 1'b0;
    foreach (ROWS[i]) begin
      send(ROWS[i].cmd, ROWS[i].a, ROWS[i].d, 1'b1);
      expect_rsp(ROWS[i].x, ROWS[i].t);
    end
    for (int i = 0; i < PAGE_BYTES; i++) send(PEW_CMD_WRITE, 16'h0400 + 16'(i), 8'(i), 1'b0);
    expect_rsp(8'h7f, 1'b0);
    send(PEW_CMD_READ, 16'h0400, 8'h00, 1'b1);
    expect_rsp(8'h00, 1'b0);
    send(PEW_CMD_READ, 16'h047f, 8'h00, 1'b1);
    expect_rsp(8'h7f, 1'b0);
    send(PEW_CMD_WRITE, 16'h0600, 8'h11, 1'b0);
    send(PEW_CMD_WRITE, 16'h0701, 8'h22, 1'b1);
    expect_rsp(8'h22, 1'b0);
    send(PEW_CMD_READ, 16'h0601, 8'h00, 1'b1);
    expect_rsp(8'h22, 1'b0);
    send(PEW_CMD_WRITE, 16'h0500, 8'h6e, 1'b0);
    expect_rsp(8'h6e, 1'b0);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    check("pins_in_reset", 8'h1c, {3'b0, device_select_n, output_drive_n, write_strobe_n,
      data_io_oe, req_ready});
    sys_rst <= 1'b0;
    send(PEW_CMD_READ, 16'h0010, 8'h00, 1'b1);
    expect_rsp(8'h3c, 1'b0);
    final_report();
  end
endmodule // tb_pew_host
